// ==== burst_sram_pkg.sv ====
package burst_sram_pkg;
    // Array geometry.
    localparam int ADDR_W  = 16;
    localparam int DATA_W  = 18;
    localparam int DEPTH   = 65536;
    // Byte lane split: lower lane is bits 0..8.
    localparam int LOW_MSB = 8;
    localparam int UP_LSB  = 9;
    // Burst counter width.
    localparam int BURST_W = 2;
    // Reset value of the burst counter and base address.
    localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
    localparam logic [ADDR_W-1:0]  ADDR_RST  = 16'h0000;
    localparam logic [DATA_W-1:0]  DATA_RST  = 18'h0_0000;
endpackage

// ==== sram_port_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Carries one array access from the controller to the storage array.
interface sram_port_if;
    import burst_sram_pkg::*;
    logic              writeEn;   // Write this cycle.
    logic              readEn;    // Read this cycle.
    logic [1:0]        laneEn;    // Byte lane write enables, high active.
    logic [ADDR_W-1:0] addr;      // Word address.
    logic [DATA_W-1:0] wdata;     // Write data.
    logic [DATA_W-1:0] rdata;     // Registered read data.
    modport ctrl (output writeEn, readEn, laneEn, addr, wdata, input rdata);
    modport mem  (input writeEn, readEn, laneEn, addr, wdata, output rdata);
endinterface
`default_nettype wire

// ==== sram_array.sv ====
`timescale 1ns/1ps
`default_nettype none
module sram_array
    import burst_sram_pkg::*;
(
    // Clock.
    input wire logic   clk,
    // Access port.
    sram_port_if.mem   port
);
    import burst_sram_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Storage, with no reset, as a real array has none.
    logic [DATA_W-1:0] mem [DEPTH];  // The words.
    logic [DATA_W-1:0] rdataQ;       // Output register.

    // Per-lane writes land at the sampling edge, no pulse shaping needed.
    always_ff @(posedge clk)
    begin
        if (port.writeEn && port.laneEn[0])
        begin
            mem[port.addr][LOW_MSB:0] <= port.wdata[LOW_MSB:0];
        end
        if (port.writeEn && port.laneEn[1])
        begin
            mem[port.addr][DATA_W-1:UP_LSB] <= port.wdata[DATA_W-1:UP_LSB];
        end
        if (port.readEn)
        begin
            rdataQ <= mem[port.addr];  // Data appear one edge later.
        end
    end

    assign port.rdata = rdataQ;
endmodule // sram_array
`default_nettype wire

// ==== pipelined_burst_sram.sv ====
`timescale 1ns/1ps
`default_nettype none
module pipelined_burst_sram
    import burst_sram_pkg::*;
(
    // Clock and reset.
    input  wire logic                              clk,
    input  wire logic                              arst_n,
    // Address and strobes.
    input  wire logic [burst_sram_pkg::ADDR_W-1:0] addr_in,
    input  wire logic                              chip_enable_n,
    input  wire logic                              processor_addr_strobe_n,
    input  wire logic                              controller_addr_strobe_n,
    input  wire logic                              burst_advance_n,
    input  wire logic                              lower_byte_write_n,
    input  wire logic                              upper_byte_write_n,
    input  wire logic                              output_enable_n,
    // Data pin as three signals.
    input  wire logic [burst_sram_pkg::DATA_W-1:0] data_io_in,
    output logic      [burst_sram_pkg::DATA_W-1:0] data_io_out,
    output logic                                   data_io_oe
);
    import burst_sram_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Input registers: every pin except output enable.
    logic [ADDR_W-1:0] addrQ;       // Sampled address.
    logic [DATA_W-1:0] dataQ;       // Sampled data.
    logic              ceQ;         // Sampled chip enable, low active.
    logic              procStrobeQ; // Sampled processor strobe.
    logic              ctrlStrobeQ; // Sampled controller strobe.
    logic              advanceQ;    // Sampled advance.
    logic              lowWriteQ;   // Sampled lower write enable.
    logic              upWriteQ;    // Sampled upper write enable.
    logic              sampledQ;    // At least one edge seen since reset.

    // Registered after reset so the first decode sees real pin levels.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            addrQ    <= ADDR_RST;
            dataQ    <= DATA_RST;
            ceQ      <= 1'b1;
            procStrobeQ <= 1'b1;
            ctrlStrobeQ <= 1'b1;
            advanceQ    <= 1'b1;
            lowWriteQ   <= 1'b1;
            upWriteQ    <= 1'b1;
            sampledQ    <= 1'b0;
        end
        else
        begin
            addrQ    <= addr_in;
            dataQ    <= data_io_in;
            ceQ      <= chip_enable_n;
            procStrobeQ <= processor_addr_strobe_n;
            ctrlStrobeQ <= controller_addr_strobe_n;
            advanceQ    <= burst_advance_n;
            lowWriteQ   <= lower_byte_write_n;
            upWriteQ    <= upper_byte_write_n;
            sampledQ <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cycle decode from the registered inputs.
    typedef enum {CYC_IDLE, CYC_DESEL, CYC_LOAD_RD, CYC_LOAD_CTRL, CYC_CONT} cycle_e;
    cycle_e cycle;

    // Priority: processor load, then controller load or deselect, then continue.
    always_comb
    begin
        if (!sampledQ)
        begin
            cycle = CYC_IDLE;  // Nothing sampled yet.
        end
        else if (!ceQ && !procStrobeQ)
        begin
            cycle = CYC_LOAD_RD;  // Processor start wins outright.
        end
        else if (!ctrlStrobeQ && ceQ)
        begin
            cycle = CYC_DESEL;  // Deselect uses no address.
        end
        else if (!ctrlStrobeQ)
        begin
            cycle = CYC_LOAD_CTRL;  // Controller start, ce low.
        end
        else
        begin
            // Processor strobe under ce high falls here and is ignored.
            cycle = CYC_CONT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst state: base address and two-bit counter.
    logic [ADDR_W-1:0]  baseAddr;       // Loaded base address.
    logic [BURST_W-1:0] burstCount;     // Offset count in the burst.
    logic               active;         // A burst is open.
    logic [ADDR_W-1:0]  next_baseAddr;
    logic [BURST_W-1:0] next_burstCount;
    logic               next_active;
    logic [ADDR_W-1:0]  accessAddr;     // Address used this cycle.
    logic               doWrite;        // Write this cycle.
    logic               doRead;         // Read this cycle.

    // The offset is XORed onto the base, so 1,2,3 flip bit 0, bit 1, both.
    function automatic logic [ADDR_W-1:0] burstAddr(input logic [ADDR_W-1:0] base,
                                                    input logic [BURST_W-1:0] cnt);
        burstAddr = {base[ADDR_W-1:BURST_W], base[BURST_W-1:0] ^ cnt};
    endfunction

    // Before the first load the counter is reset to zero but not meaningful.
    always_comb
    begin
        next_baseAddr   = baseAddr;
        next_burstCount = burstCount;
        next_active     = active;
        accessAddr      = burstAddr(baseAddr, burstCount);
        doWrite         = 1'b0;
        doRead          = 1'b0;
        case (cycle)
            CYC_LOAD_RD:
            begin
                // Write enables ignored; a write needs a later cycle.
                next_baseAddr   = addrQ;
                next_burstCount = BURST_RST;
                next_active     = 1'b1;
                accessAddr      = addrQ;
                doRead          = 1'b1;
            end
            CYC_LOAD_CTRL:
            begin
                next_baseAddr   = addrQ;
                next_burstCount = BURST_RST;
                next_active     = 1'b1;
                accessAddr      = addrQ;
                doWrite         = !lowWriteQ || !upWriteQ;
                doRead          = lowWriteQ && upWriteQ;
            end
            CYC_DESEL:
            begin
                next_active = 1'b0;  // No access.
            end
            CYC_CONT:
            begin
                if (!advanceQ)
                begin
                    // Step first, wrapping to base after the fourth.
                    next_burstCount = burstCount + 2'h1;
                    accessAddr      = burstAddr(baseAddr, next_burstCount);
                end
                // Advance high keeps the address: a wait state.
                doWrite = active && (!lowWriteQ || !upWriteQ);
                doRead  = active && lowWriteQ && upWriteQ;
            end
            default:
            begin
                next_active = 1'b0;
            end
        endcase
    end

    // Registers only.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            baseAddr   <= ADDR_RST;
            burstCount <= BURST_RST;
            active     <= 1'b0;
        end
        else
        begin
            baseAddr   <= next_baseAddr;
            burstCount <= next_burstCount;
            active     <= next_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array access.
    sram_port_if port ();

    assign port.writeEn = doWrite;
    assign port.readEn  = doRead;
    assign port.laneEn  = {!upWriteQ, !lowWriteQ};
    assign port.addr    = accessAddr;
    assign port.wdata   = dataQ;

    sram_array u_array
    (
        .clk  (clk),
        .port (port)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output drive state: the read of this edge shows after the next.
    logic readPending;       // Output register holds a fresh read.
    logic next_readPending;

    // Writes and deselect drop the drivers regardless of output enable.
    always_comb
    begin
        next_readPending = doRead;
    end

    // Drivers stay off from reset until a read fills the register.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            readPending <= 1'b0;
        end
        else
        begin
            readPending <= next_readPending;
        end
    end

    // Output enable is not sampled; it gates the driver directly.
    // The host keeps it high around a read-to-write turn.
    assign data_io_oe  = readPending && !output_enable_n;
    assign data_io_out = port.rdata;
endmodule // pipelined_burst_sram
`default_nettype wire

// ==== burst_sram_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module burst_sram_asserts
    import burst_sram_pkg::*;
(
    // Clock and reset.
    input wire logic                              clk,
    input wire logic                              arst_n,
    // Strobes and enables.
    input wire logic                              chip_enable_n,
    input wire logic                              processor_addr_strobe_n,
    input wire logic                              controller_addr_strobe_n,
    input wire logic                              burst_advance_n,
    input wire logic                              lower_byte_write_n,
    input wire logic                              upper_byte_write_n,
    input wire logic                              output_enable_n,
    // Data pin outputs.
    input wire logic [burst_sram_pkg::DATA_W-1:0] data_io_out,
    input wire logic                              data_io_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Either lane enable low makes the cycle a write.
    wire wr = !(lower_byte_write_n && upper_byte_write_n);
    // Continuation cycles: no strobe counts, the processor one is masked by chip enable.
    wire cont = controller_addr_strobe_n && (processor_addr_strobe_n || chip_enable_n);
    sequence procRead; !chip_enable_n && !processor_addr_strobe_n; endsequence
    sequence ctrlLoad; !chip_enable_n && processor_addr_strobe_n && !controller_addr_strobe_n; endsequence
    sequence suspRead; cont && burst_advance_n && !wr; endsequence
    reset_quiet_a: assert property ($rose(arst_n) |-> !data_io_oe ##1 !data_io_oe)
        else $error("pin driven right after reset");
    oe_gate_a: assert property (output_enable_n |-> !data_io_oe)
        else $error("pin driven with output enable high");
    proc_read_a: assert property (procRead ##2 !output_enable_n |-> data_io_oe)
        else $error("processor read not driven two edges later");
    ctrl_read_a: assert property (ctrlLoad ##0 !wr ##2 !output_enable_n |-> data_io_oe)
        else $error("controller read not driven");
    ctrl_write_a: assert property (ctrlLoad ##0 wr |-> ##2 !data_io_oe)
        else $error("pin driven after a write");
    deselect_a: assert property (chip_enable_n && !controller_addr_strobe_n |-> ##2 !data_io_oe)
        else $error("pin driven after deselect");
    suspend_hold_a: assert property (procRead ##1 suspRead |-> ##2 $stable(data_io_out))
        else $error("suspend cycle changed the read word");
    burst_read_a: assert property (procRead ##1 (cont && !wr) ##2 !output_enable_n |-> data_io_oe)
        else $error("burst read not driven");
    burst_write_a: assert property (procRead ##1 (cont && wr) |-> ##2 !data_io_oe)
        else $error("burst write drove the pin");
endmodule // burst_sram_asserts
bind pipelined_burst_sram burst_sram_asserts u_asserts (.clk(clk), .arst_n(arst_n),
    .chip_enable_n(chip_enable_n), .processor_addr_strobe_n(processor_addr_strobe_n),
    .controller_addr_strobe_n(controller_addr_strobe_n), .burst_advance_n(burst_advance_n),
    .lower_byte_write_n(lower_byte_write_n), .upper_byte_write_n(upper_byte_write_n),
    .output_enable_n(output_enable_n), .data_io_out(data_io_out), .data_io_oe(data_io_oe));
`default_nettype wire

// ==== shared_bus_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module shared_bus_model
    import burst_sram_pkg::*;
(
    // Clock.
    input  wire logic                              clk,
    // Device and host drivers of the data pin.
    input  wire logic [burst_sram_pkg::DATA_W-1:0] devOut,
    input  wire logic                              devOe,
    input  wire logic [burst_sram_pkg::DATA_W-1:0] hostData,
    input  wire logic                              hostDrive,
    // Resolved level and a clash flag.
    output logic      [burst_sram_pkg::DATA_W-1:0] wireLevel,
    output logic                                   clash
);
    logic [DATA_W-1:0] lastLevel = '0;  // Level seen at the last edge.
    // The line has no pull, so a released line shows a changing pattern, not stale data.
    always_ff @(posedge clk) lastLevel <= wireLevel;
    always_comb wireLevel = devOe ? devOut : (hostDrive ? hostData : ~lastLevel);
    assign clash = devOe && hostDrive;
endmodule // shared_bus_model
`default_nettype wire

// ==== pipelined_burst_sram_64kx18_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module pipelined_burst_sram_64kx18_test;
    import burst_sram_pkg::*;
    typedef struct packed {logic [1:0] kind; logic [DATA_W-1:0] data;} expect_s;
    localparam logic [ADDR_W-1:0] BASE = 16'h1236;  // Low bits 2'b10 make the burst wrap from 2'b11 to 2'b00.
    logic              clk = 1'b0, arst_n = 1'b0, ceN = 1'b1, pN = 1'b1, cN = 1'b1;
    logic              advanceN = 1'b1, lowWrN = 1'b1, upWrN = 1'b1, oeN = 1'b0;
    logic              hostDrive = 1'b0;
    logic              devOe, clash;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] hostData = '0, devOut, wireLevel;
    logic [DATA_W-1:0] mem [4];  // Expected words at BASE with offsets 0..3.
    expect_s           expQ [$];  // Answers still in the pipeline.
    int                num_errors = 0, samples_checked = 0;
    initial forever #50 clk = ~clk;
    pipelined_burst_sram dut (.clk(clk), .arst_n(arst_n), .addr_in(addr), .chip_enable_n(ceN),
        .processor_addr_strobe_n(pN), .controller_addr_strobe_n(cN), .burst_advance_n(advanceN),
        .lower_byte_write_n(lowWrN), .upper_byte_write_n(upWrN), .output_enable_n(oeN),
        .data_io_in(wireLevel), .data_io_out(devOut), .data_io_oe(devOe));
    shared_bus_model bus (.clk(clk), .devOut(devOut), .devOe(devOe), .hostData(hostData),
        .hostDrive(hostDrive), .wireLevel(wireLevel), .clash(clash));
    task automatic check(string what, logic [DATA_W-1:0] expv, logic [DATA_W-1:0] got);
        samples_checked++;
        if (got !== expv)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, expv, got);
        end
    endtask
    // One cycle of the bus; the answer of the previous cycle is judged on return.
    task automatic step(logic ce, p, c, advance, lowWr, upWr, logic [ADDR_W-1:0] a,
                        logic [DATA_W-1:0] d, logic [1:0] kind, logic [DATA_W-1:0] ex);
        expect_s e;
        {ceN, pN, cN, advanceN, lowWrN, upWrN, addr, hostData} = {ce, p, c, advance, lowWr, upWr, a, d};
        hostDrive = !(lowWr && upWr);
        oeN = hostDrive;  // Output enable is lifted whenever the host drives.
        expQ.push_back({kind, ex});
        @(posedge clk);
        #10;
        check("bus clash", '0, DATA_W'(clash));
        if (expQ.size() == 2)
        begin
            e = expQ.pop_front();
            if (e.kind == 2'd1)
            begin
                check("read drive", 1, DATA_W'(devOe));
                check("read data", e.data, devOut);
            end
            else if (e.kind == 2'd2)
                check("pin released", '0, DATA_W'(devOe));
        end
    endtask
    // Deselect cycles drain the pipeline between tests.
    task automatic idle;
        repeat (2) step(1, 1, 0, 1, 1, 1, '0, '0, 2, '0);
    endtask
    task automatic test_lane_writes;
        mem = '{18'h3_c0a0, 18'h0_5a01, 18'h2_a502, 18'h1_0f03};
        step(0, 1, 0, 1, 0, 0, BASE, mem[0], 2, '0);
        for (int i = 1; i < 4; i++)
            step(1, 1, 1, 0, 0, 0, BASE, mem[i], 2, '0);
        step(0, 1, 0, 1, 0, 1, BASE, 18'h0_0155, 2, '0);
        mem[0][8:0] = 9'h155;
        step(0, 1, 0, 1, 1, 0, BASE ^ 16'h0001, 18'h3_fe00, 2, '0);
        mem[1][17:9] = 9'h1ff;
        idle();
        $display("test lane writes done");
    endtask
    task automatic test_read_burst;
        step(0, 0, 1, 1, 1, 1, BASE, '0, 1, mem[0]);
        step(1, 1, 1, 1, 1, 1, BASE, '0, 1, mem[0]);
        step(1, 0, 1, 0, 1, 1, BASE, '0, 1, mem[1]);
        oeN = 1'b1;
        #1;
        check("oe off", '0, DATA_W'(devOe));
        oeN = 1'b0;
        #1;
        check("oe on", 1, DATA_W'(devOe));
        for (int i = 2; i < 6; i++)
            step(0, 1, 1, 0, 1, 1, BASE, '0, 1, mem[i % 4]);
        idle();
        $display("test read burst done");
    endtask
    task automatic test_proc_write;
        step(0, 0, 1, 1, 1, 1, 16'h00f0, '0, 0, '0);
        step(1, 1, 1, 1, 0, 0, 16'h00f0, 18'h2_5a5a, 2, '0);
        step(1, 1, 0, 1, 0, 0, 16'h00f0, 18'h1_1111, 2, '0);
        step(0, 0, 0, 1, 0, 0, 16'h00f0, 18'h0_3333, 1, 18'h2_5a5a);
        step(0, 1, 0, 1, 1, 1, 16'h00f0, '0, 1, 18'h2_5a5a);
        idle();
        $display("test processor write done");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        #10;
        arst_n = 1'b1;
        check("oe after reset", '0, DATA_W'(devOe));
        test_lane_writes();
        test_read_burst();
        test_proc_write();
        summarize();
    end
endmodule // pipelined_burst_sram_64kx18_test
`default_nettype wire
